// File: logic/awp_map.svh
/*
  Constants of the arbitrary waveform player: rates, limits, field positions, timing counts.
  Assumes it is included by the package and by the bench after the package.
*/
`ifndef AWP_MAP_SVH
`define AWP_MAP_SVH

// ----------------------------------------
// Rates and timing
// ----------------------------------------
`define AWP_MCLK_MHZ   8'h28
`define AWP_CLK_MHZ    8'h7D
`define AWP_MCLK_HZ    34'h0262_5A00
`define AWP_CLK_NS     8
`define AWP_SYNC_NS    25
`define AWP_SYNC_CYC   ((`AWP_SYNC_NS + `AWP_CLK_NS - 1) / `AWP_CLK_NS)
`define AWP_DIV_RST    34'h0_0000_0001

// ----------------------------------------
// Limits and command fields
// ----------------------------------------
`define AWP_RAM_DEPTH  16384
`define AWP_MAX_PTS    15'h3FAC
`define AWP_MAX_X      14'h3FAB
`define AWP_MAX_VERT   13'h1800
`define AWP_MIN_PTS    15'h0008
`define AWP_X_LSB      12
`define AWP_X_MSB      25
`define AWP_Y_MSB      11
`define AWP_FIFO_DEPTH 4

`endif

// File: logic/awp_pkg.sv
/*
  Types of the arbitrary waveform player: commands, loader states, DAC sample.
  Assumes awp_map.svh sits beside it.
*/
package awp_pkg;
  `include "awp_map.svh"

  typedef enum logic [2:0] {
    AWP_CLEAR  = 3'h0,
    AWP_FORMAT = 3'h1,
    AWP_POINT  = 3'h2,
    AWP_VERTEX = 3'h3,
    AWP_FREQ   = 3'h4
  } awp_op_e;

  // Gray codes along idle, divide, fill
  typedef enum logic [1:0] {
    AWP_IDLE = 2'h0,
    AWP_DIV  = 2'h1,
    AWP_FILL = 2'h3,
    AWP_CLR  = 2'h2
  } awp_st_e;

  typedef struct packed {
    awp_op_e     op;
    logic [31:0] arg;
  } awp_cmd_s;

  typedef struct packed {
    logic signed [11:0] code;
    logic               sync_n;
  } awp_dac_s;
endpackage

// File: logic/awp_player.sv
/*
  Arbitrary waveform player: command FIFO, waveform RAM loader with vertex interpolation,
  sample-rate divider and RAM readout to a 12-bit DAC with a start-of-waveform sync pulse.
  Assumes commands come from firmware on clk; the DAC latches dac.code every clk cycle.
*/

// ----------------------------------------
// Command FIFO
// ----------------------------------------
module awp_fifo #(
  parameter int W     = 35,
  parameter int DEPTH = 4
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wp_q, wp_d, rp_q, rp_d;

  assign in_ready  = (wp_q - rp_q) != (AW+1)'(DEPTH);
  assign out_valid = wp_q != rp_q;
  assign out_data  = mem[rp_q[AW-1:0]];

  always_comb begin
    wp_d = wp_q + (AW+1)'(in_valid && in_ready);
    rp_d = rp_q + (AW+1)'(out_valid && out_ready);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end

  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      mem[wp_q[AW-1:0]] <= in_data;
    end
  end
endmodule

// ----------------------------------------
// Player
// ----------------------------------------
module awp_player import awp_pkg::*; #(
  parameter int FIFO_DEPTH = `AWP_FIFO_DEPTH
) (
  input  wire logic     clk,
  input  wire logic     rst,
  input  wire logic     cmd_valid,
  output logic          cmd_ready,
  input  wire awp_cmd_s cmd,
  output awp_dac_s      dac,
  output logic          busy,
  output logic          rejected,
  output logic          fmt_vector,
  output logic [33:0]   sample_div
);
  localparam int SYNC_CYC = `AWP_SYNC_CYC;

  logic               f_valid, f_ready;
  logic [$bits(awp_cmd_s)-1:0] f_bits;
  awp_cmd_s           c;
  logic signed [11:0] ram [`AWP_RAM_DEPTH];

  awp_fifo #(.W($bits(awp_cmd_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (cmd_valid),
    .in_ready  (cmd_ready),
    .in_data   (cmd),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_bits)
  );
  assign c = awp_cmd_s'(f_bits);

  // ----------------------------------------
  // Loader state
  // ----------------------------------------
  awp_st_e            st_q, st_d;
  logic               fmt_q, fmt_d, have_q, have_d, job_q, job_d, rej_q, rej_d, neg_q, neg_d;
  logic [14:0]        len_q, len_d;
  logic [12:0]        nv_q, nv_d;
  logic [13:0]        lx_q, lx_d, tx_q, tx_d, pos_q, pos_d, fr_q, fr_d, err_q, err_d;
  logic signed [11:0] ly_q, ly_d, ty_q, ty_d, val_q, val_d;
  logic [11:0]        fq_q, fq_d;
  logic [33:0]        rem_q, rem_d, quo_q, quo_d, dsr_q, dsr_d, div_q, div_d;
  logic [5:0]         bit_q, bit_d;
  logic [2:0]         clr_q, clr_d;
  logic               we;
  logic [13:0]        wa, x_in, dx;
  logic signed [11:0] wd, y_in;
  logic signed [12:0] dy, stp;
  logic [33:0]        rem_s;
  logic [14:0]        err_n;
  logic               empty;

  assign x_in  = c.arg[`AWP_X_MSB:`AWP_X_LSB];
  assign y_in  = c.arg[`AWP_Y_MSB:0];
  assign empty = (len_q == '0) && (nv_q == '0);
  assign dx    = tx_q - lx_q;

  always_comb begin
    st_d = st_q;   fmt_d = fmt_q; have_d = have_q; job_d = job_q; neg_d = neg_q;
    len_d = len_q; nv_d = nv_q;   lx_d = lx_q;     ly_d = ly_q;   tx_d = tx_q;
    ty_d = ty_q;   pos_d = pos_q; fr_d = fr_q;     err_d = err_q; val_d = val_q;
    fq_d = fq_q;   rem_d = rem_q; quo_d = quo_q;   dsr_d = dsr_q; div_d = div_q;
    bit_d = bit_q; clr_d = clr_q; rej_d = 1'b0;
    we = 1'b0;     wa = '0;       wd = '0;         f_ready = 1'b0;
    dy = 13'(ty_q) - 13'(ly_q);
    rem_s = {rem_q[32:0], quo_q[33]};
    err_n = 15'(err_q) + 15'(fr_q);
    stp = 13'(fq_q) + 13'(err_n >= 15'(dx));
    unique case (st_q)
      AWP_IDLE: begin
        f_ready = f_valid;                     // Back-pressure: only drained while idle
        if (f_valid) begin
          unique case (c.op)
            AWP_CLEAR: begin
              len_d = '0; nv_d = '0; have_d = 1'b0; lx_d = '0; ly_d = '0;
              clr_d = '0; st_d = AWP_CLR;
            end
            AWP_FORMAT: begin
              if (empty) fmt_d = c.arg[0];
              else rej_d = 1'b1;
            end
            AWP_POINT: begin
              if (!fmt_q && len_q < `AWP_MAX_PTS) begin
                we = 1'b1; wa = len_q[13:0]; wd = y_in;
                len_d = len_q + 15'h0001;
              end else rej_d = 1'b1;
            end
            AWP_VERTEX: begin
              if (!fmt_q || nv_q >= `AWP_MAX_VERT || x_in > `AWP_MAX_X || (have_q && x_in < lx_q)) begin
                rej_d = 1'b1;
              end else begin
                nv_d = nv_q + 13'h0001;
                tx_d = x_in; ty_d = y_in;
                if (!have_q && x_in == '0) begin
                  we = 1'b1; wa = '0; wd = y_in;
                  have_d = 1'b1; lx_d = '0; ly_d = y_in;
                end else if (!have_q || x_in != lx_q) begin
                  if (!have_q) begin
                    we = 1'b1; wa = '0; wd = '0;
                    have_d = 1'b1; lx_d = '0; ly_d = '0;
                  end
                  job_d = 1'b1; bit_d = '0; st_d = AWP_DIV;
                end
              end
            end
            AWP_FREQ: begin
              if (c.arg == '0) rej_d = 1'b1;
              else begin
                job_d = 1'b0; bit_d = '0; rem_d = '0; st_d = AWP_DIV;
                quo_d = `AWP_MCLK_HZ + 34'(c.arg[31:1]);
                dsr_d = 34'(c.arg);
              end
            end
            default: rej_d = 1'b1;
          endcase
        end
      end
      AWP_DIV: begin
        if (bit_q == '0 && job_q) begin        // Vertex divide |dy| by dx; first cycle loads
          neg_d = dy[12];
          rem_d = '0;
          quo_d = 34'(dy[12] ? -dy : dy);
          dsr_d = 34'(dx);
          bit_d = 6'h01;
        end else begin
          if (rem_s >= dsr_q) begin
            rem_d = rem_s - dsr_q; quo_d = {quo_q[32:0], 1'b1};
          end else begin
            rem_d = rem_s;         quo_d = {quo_q[32:0], 1'b0};
          end
          bit_d = bit_q + 6'h01;
          if (bit_q == 6'(job_q ? 34 : 33)) begin
            if (!job_q) begin
              div_d = (quo_d == '0) ? `AWP_DIV_RST : quo_d;
              st_d  = AWP_IDLE;
            end else begin
              fq_d = quo_d[11:0]; fr_d = rem_d[13:0]; err_d = '0;
              val_d = ly_q; pos_d = lx_q + 14'h0001; st_d = AWP_FILL;
            end
          end
        end
      end
      AWP_FILL: begin                          // remainder spread keeps the total exact
        err_d = (err_n >= 15'(dx)) ? 14'(err_n - 15'(dx)) : err_n[13:0];
        val_d = neg_q ? 12'(13'(val_q) - stp) : 12'(13'(val_q) + stp);
        we = 1'b1; wa = pos_q; wd = val_d;
        pos_d = pos_q + 14'h0001;
        if (pos_q == tx_q) begin
          lx_d = tx_q; ly_d = ty_q; st_d = AWP_IDLE;
        end
      end
      AWP_CLR: begin                           // zero the pad area
        we = 1'b1; wa = 14'(clr_q); wd = '0;
        clr_d = clr_q + 3'h1;
        if (clr_q == 3'h7) st_d = AWP_IDLE;
      end
      default: st_d = AWP_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= AWP_IDLE; fmt_q <= 1'b0; have_q <= 1'b0; job_q <= 1'b0; neg_q <= 1'b0;
      len_q <= '0; nv_q <= '0; lx_q <= '0; ly_q <= '0; tx_q <= '0; ty_q <= '0;
      pos_q <= '0; fr_q <= '0; err_q <= '0; val_q <= '0; fq_q <= '0; rem_q <= '0;
      quo_q <= '0; dsr_q <= '0; div_q <= `AWP_DIV_RST; bit_q <= '0; clr_q <= '0; rej_q <= 1'b0;
    end else begin
      st_q <= st_d; fmt_q <= fmt_d; have_q <= have_d; job_q <= job_d; neg_q <= neg_d;
      len_q <= len_d; nv_q <= nv_d; lx_q <= lx_d; ly_q <= ly_d; tx_q <= tx_d; ty_q <= ty_d;
      pos_q <= pos_d; fr_q <= fr_d; err_q <= err_d; val_q <= val_d; fq_q <= fq_d; rem_q <= rem_d;
      quo_q <= quo_d; dsr_q <= dsr_d; div_q <= div_d; bit_q <= bit_d; clr_q <= clr_d; rej_q <= rej_d;
    end
  end

  always_ff @(posedge clk) begin
    if (we) begin
      ram[wa] <= wd;
    end
  end

  // ----------------------------------------
  // Sample timing and readout
  // ----------------------------------------
  // 40 MHz master ticks from a 40/125 accumulator; jitter of one clk per sample is the trade
  logic [6:0]  mt_q, mt_d;
  logic [7:0]  mt_sum;
  logic        tick, smp_en;
  logic [33:0] sc_q, sc_d;
  logic [13:0] addr_q, addr_d;
  logic [14:0] play_len;
  logic [2:0]  sy_q, sy_d;
  logic signed [11:0] code_q, code_d;

  assign mt_sum   = {1'b0, mt_q} + `AWP_MCLK_MHZ;
  assign tick     = mt_sum >= `AWP_CLK_MHZ;
  assign smp_en   = tick && (sc_q >= div_q - 34'h1);
  assign play_len = fmt_q ? (have_q ? 15'(lx_q) + 15'h0001 : '0)
                          : ((len_q < `AWP_MIN_PTS) ? `AWP_MIN_PTS : len_q);

  always_comb begin
    mt_d   = tick ? 7'(mt_sum - `AWP_CLK_MHZ) : mt_sum[6:0];
    sc_d   = smp_en ? '0 : sc_q + 34'(tick);
    addr_d = addr_q;
    code_d = code_q;
    sy_d   = (sy_q != '0) ? sy_q - 3'h1 : sy_q;
    if (smp_en) begin
      if (play_len == '0) begin
        addr_d = '0;
        code_d = '0;
      end else begin
        addr_d = (15'(addr_q) >= play_len - 15'h0001) ? '0 : addr_q + 14'h0001;
        code_d = ram[addr_d];
        if (addr_d == '0) sy_d = 3'(SYNC_CYC);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mt_q <= '0; sc_q <= '0; addr_q <= 14'h3FFF; code_q <= '0; sy_q <= '0;
    end else begin
      mt_q <= mt_d; sc_q <= sc_d; addr_q <= addr_d; code_q <= code_d; sy_q <= sy_d;
    end
  end

  // One driver for the whole struct: member-wise continuous assigns would drive one variable twice
  assign dac         = '{code: code_q, sync_n: (sy_q == '0)};
  assign busy        = st_q != AWP_IDLE;
  assign rejected    = rej_q;
  assign fmt_vector  = fmt_q;
  assign sample_div  = div_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  tick_spacing_a: assert property (tick |=> !tick) else $error("master ticks too close");
  div_nonzero_a: assert property (div_q != '0) else $error("divisor is zero");
  hold_point_a: assert property ($changed(code_q) |-> $past(smp_en)) else $error("code moved off sample");
  sync_width_a: assert property ($fell(dac.sync_n) |-> !dac.sync_n [*4] ##1 dac.sync_n)
    else $error("sync pulse width wrong");
  sync_wrap_a: assert property ($fell(dac.sync_n) |-> addr_q == '0 && $past(smp_en))
    else $error("sync not at wrap");
  point_load_a: assert property (f_ready && c.op == AWP_POINT && !fmt_q && len_q < `AWP_MAX_PTS
    |=> len_q == $past(len_q) + 15'h0001) else $error("point not loaded");
  fmt_lock_a: assert property ($changed(fmt_q) |-> $past(empty)) else $error("format changed unclear");
  clear_empty_a: assert property (f_ready && c.op == AWP_CLEAR |=> empty ##8 st_q == AWP_IDLE)
    else $error("clear incomplete");
  // Short list must play through address 7 before wrapping, whatever its own length
  pad_min_a: assert property (!fmt_q && len_q < `AWP_MIN_PTS && smp_en && addr_q == 14'h0007
    |=> addr_q == '0) else $error("short list not padded to eight");
  vert_limit_a: assert property (nv_q <= `AWP_MAX_VERT) else $error("too many vertices");
endmodule

// File: tb/awp_dac_model.sv
/*
  Behavioural model of the waveform DAC and its sync input: records each waveform frame.
  Assumes dac is registered on clk and that a frame begins where sync_n falls.
*/
module awp_dac_model import awp_pkg::*; (
  input wire logic     clk,
  input wire logic     rst,
  input wire awp_dac_s dac
);
  timeunit 1ns;
  timeprecision 1ps;

  logic signed [11:0] cur_q[$];
  logic signed [11:0] last_q[$];
  int                 per_cnt;
  int                 last_per;
  int                 low_cnt;
  int                 last_low;
  int                 n_frames;
  logic               sync_prev;

  // ----------------------------------------
  // Frame capture
  // ----------------------------------------
  // Only code changes are kept: equal neighbours cannot be told apart at the pins
  always @(posedge clk) begin
    if (rst) begin
      n_frames  = 0;
      per_cnt   = 0;
      low_cnt   = 0;
      sync_prev = 1'b1;
      cur_q.delete();
    end else begin
      per_cnt++;
      if (dac.sync_n === 1'b0) begin
        low_cnt++;
      end else if (low_cnt != 0) begin
        last_low = low_cnt;
        low_cnt  = 0;
      end
      if (sync_prev === 1'b1 && dac.sync_n === 1'b0) begin
        last_q   = cur_q;
        last_per = per_cnt;
        per_cnt  = 0;
        n_frames++;
        cur_q.delete();
        cur_q.push_back(dac.code);
      end else if (cur_q.size() > 0 && dac.code !== cur_q[$]) begin
        cur_q.push_back(dac.code);
      end
      sync_prev = dac.sync_n;
    end
  end
endmodule

// File: tb/awp_player_tb.sv
/*
  Self-checking bench of the waveform player: loads, formats, divisor and playback.
  Assumes the DAC model beside it and awp_map.svh on the include path.
*/
`include "awp_map.svh"
module awp_player_tb import awp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  typedef logic signed [11:0] awp_codes_t[$];

  logic     clk;
  logic     rst;
  logic     cmd_valid;
  logic     cmd_ready;
  awp_cmd_s cmd;
  awp_dac_s dac;
  logic     busy;
  logic     rejected;
  logic     fmt_vector;
  logic [33:0] sample_div;
  int       failures;
  int       n_checks;
  int       n_rej;
  logic     saw_full;

  awp_player dut_u (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
                    .dac(dac), .busy(busy), .rejected(rejected), .fmt_vector(fmt_vector),
                    .sample_div(sample_div));
  awp_dac_model dac_u (.clk(clk), .rst(rst), .dac(dac));

  always #4 clk = ~clk;
  always @(posedge clk) if (rejected === 1'b1) n_rej++;

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("ERROR at %0t: %s", $time, msg);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Called just after a rising edge; valid stays up for back-to-back sends
  task automatic send(input awp_op_e op, input logic [31:0] arg);
    int k;
    cmd_valid <= 1'b1;
    cmd       <= '{op: op, arg: arg};
    k = 0;
    do begin
      @(negedge clk);
      k++;
      if (cmd_ready === 1'b0) saw_full = 1'b1;
    end while (cmd_ready !== 1'b1 && k < 200);
    chk(k < 200, "command never accepted");
    @(posedge clk);
  endtask

  // Queue drained once busy stays low several cycles in a row
  task automatic wait_idle();
    int k;
    int quiet;
    cmd_valid <= 1'b0;
    k = 0;
    quiet = 0;
    while (quiet < 6 && k < 20000) begin
      @(negedge clk);
      k++;
      quiet = (busy === 1'b0) ? quiet + 1 : 0;
    end
    chk(quiet >= 6, "loader never went idle");
    @(posedge clk);
  endtask

  // A frame may carry one leading code left over from the previous pass
  task automatic chk_frame(input awp_codes_t exp, input int per);
    awp_codes_t got;
    int         n0;
    int         k;
    n0 = dac_u.n_frames;
    k = 0;
    while (dac_u.n_frames < n0 + 2 && k < 5000) begin
      @(negedge clk);
      k++;
    end
    got = dac_u.last_q;
    if (got.size() == exp.size() + 1) void'(got.pop_front());
    chk(got.size() == exp.size(), "frame length differs");
    foreach (exp[i]) if (i < got.size()) chk(got[i] === exp[i], "sample value differs");
    chk(dac_u.last_per >= per - 1 && dac_u.last_per <= per + 1, "waveform period wrong");
    chk(dac_u.last_low == `AWP_SYNC_CYC, "sync pulse width wrong");
    @(posedge clk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Outputs are read mid-cycle, clear of the edge that launches them
  task automatic t_reset();
    @(negedge clk);
    chk(dac.sync_n === 1'b1 && dac.code === 12'h000, "dac not idle after reset");
    chk(busy === 1'b0 && fmt_vector === 1'b0 && cmd_ready === 1'b1, "flags wrong after reset");
    chk(sample_div === `AWP_DIV_RST, "divisor reset value wrong");
    @(posedge clk);
    $display("test reset done");
  endtask

  task automatic t_point();
    awp_codes_t e;
    int         r0;
    r0 = n_rej;
    saw_full = 1'b0;
    send(AWP_CLEAR, 32'h0000_0000);
    send(AWP_FORMAT, 32'h0000_0000);
    send(AWP_FREQ, 32'h0098_9680);
    send(AWP_POINT, 32'h0000_0000);
    send(AWP_POINT, 32'h0000_0190);
    send(AWP_POINT, 32'h0000_0320);
    send(AWP_POINT, 32'h0000_04B0);
    send(AWP_VERTEX, 32'h0000_4190);
    send(AWP_FORMAT, 32'h0000_0001);
    wait_idle();
    chk(saw_full, "queue never filled");
    chk(n_rej - r0 == 2, "vertex or format change not refused");
    chk(fmt_vector === 1'b0, "format changed with data present");
    chk(sample_div === 34'h0_0000_0004, "divisor for 10 MHz wrong");
    e = '{12'h000, 12'h190, 12'h320, 12'h4B0, 12'h000};
    chk_frame(e, 8 * 4 * 125 / 40);
    $display("test point done");
  endtask

  task automatic t_freq();
    logic [31:0] f[7];
    logic [33:0] n[7];
    int          r0;
    f = '{32'h0262_5A00, 32'h00C6_5D40, 32'h0131_2D00, 32'h00F4_2400, 32'h006A_CFC0, 32'h0000_0001,
          32'h0098_9680};
    n = '{34'h1, 34'h3, 34'h2, 34'h3, 34'h6, 34'h0_0262_5A00, 34'h4};
    foreach (f[i]) begin
      send(AWP_FREQ, f[i]);
      wait_idle();
      chk(sample_div === n[i], "rounded divisor wrong");
    end
    r0 = n_rej;
    send(AWP_FREQ, 32'h0000_0000);
    wait_idle();
    chk(n_rej - r0 == 1 && sample_div === 34'h4, "zero frequency not refused");
    $display("test freq done");
  endtask

  task automatic t_vertex();
    awp_codes_t e;
    int         r0;
    send(AWP_CLEAR, 32'h0000_0000);
    send(AWP_FORMAT, 32'h0000_0001);
    wait_idle();
    chk(fmt_vector === 1'b1, "format change after clear refused");
    r0 = n_rej;
    send(AWP_VERTEX, 32'h0000_4190);
    send(AWP_VERTEX, 32'h0000_43E7);
    send(AWP_VERTEX, 32'h0000_2032);
    send(AWP_VERTEX, 32'h03FA_C000);
    send(AWP_POINT, 32'h0000_0190);
    send(AWP_VERTEX, 32'h0000_6F38);
    wait_idle();
    chk(n_rej - r0 == 3, "bad vertex or point not refused");
    e = '{12'h000, 12'h064, 12'h0C8, 12'h12C, 12'h190, 12'h064, 12'hF38};
    chk_frame(e, 7 * 4 * 125 / 40);
    send(AWP_CLEAR, 32'h0000_0000);
    send(AWP_FORMAT, 32'h0000_0000);
    wait_idle();
    chk(fmt_vector === 1'b0, "point format not restored");
    e = '{12'h000};
    chk_frame(e, 8 * 4 * 125 / 40);
    $display("test vertex done");
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    clk       = 1'b0;
    rst       = 1'b1;
    cmd_valid = 1'b0;
    cmd       = '{op: AWP_CLEAR, arg: 32'h0000_0000};
    failures  = 0;
    n_checks  = 0;
    n_rej     = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_point();
    t_freq();
    t_vertex();
    print_verdict();
  end

  // Whole run needs under 2k cycles; this allows 50k cycles, many times that
  initial begin
    #400000;
    failures++;
    $display("ERROR at %0t: run did not finish", $time);
    print_verdict();
  end
endmodule
